// ---- rtl/wdt_consts.svh ----
// Constants for the watchdog timer core: register map, fields, resets.
// Assumes a 32-bit register port with word-aligned byte addresses.
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH
`define WDT_LF_HZ        31000
`define WDT_TICK_MS      1
`define WDT_PRESC_MAX    5'h1e
`define WDT_CNT_W        18
`define WDT_PS_MAX       5'h12
`define WDT_PS_DEFAULT   5'h0b
`define WDT_ADDR_CTRL    8'h00
`define WDT_ADDR_STATUS  8'h04
`define WDT_ADDR_IRQ_STS 8'h08
`define WDT_ADDR_IRQ_MSK 8'h0c
`define WDT_ADDR_COUNT   8'h10
`define WDT_CTRL_SWEN    0
`define WDT_CTRL_PS_LO   1
`define WDT_CTRL_PS_HI   5
`define WDT_IRQ_W        2
`define WDT_IRQ_RST      0
`define WDT_IRQ_WAKE     1
`endif

// ---- rtl/wdt_pkg.sv ----
// Types for the watchdog timer core.
// Assumes nothing beyond the constants header.
package wdt_pkg;
	typedef enum logic [1:0] {
		MODE_OFF     = 2'b00,
		MODE_SW      = 2'b01,
		MODE_NOSLEEP = 2'b10,
		MODE_ON      = 2'b11
	} wdt_mode_t;
endpackage

// ---- rtl/watchdog_timer_core.sv ----
// Watchdog timer core with a plain register port and interrupt output.
// Assumes core-side inputs are on core_clk; the low-frequency oscillator
// arrives as an asynchronous pin and is synchronised here.
//
// The register offsets and strobed register access are this design's own decisions.
`include "wdt_consts.svh"

module watchdog_timer_core (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        reset,
	// Low-frequency oscillator pin
	input  wire logic        low_freq_internal_osc,
	// Configuration and core status
	input  wire logic [1:0]  watchdog_mode_config,
	input  wire logic        clear_watchdog_instruction,
	input  wire logic        core_asleep,
	input  wire logic        osc_fail,
	input  wire logic        oscillator_startup_timer,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// Events and flags
	output logic             reset_request,
	output logic             wake_request,
	output logic             timeout_status_flag,
	output logic             sleep_entry_flag,
	output logic             watchdog_active,
	output logic             irq
);

	localparam int CW = `WDT_CNT_W;

	logic [2:0]              lf_sync_r;
	logic [4:0]              presc_r;
	logic                    tick;
	logic                    lf_rise;
	logic [CW-1:0]           count_r;
	logic                    asleep_r;
	logic                    sleep_enter;
	logic                    sleep_exit;
	logic                    software_watchdog_enable;
	logic [4:0]              timeout_period_select;
	logic                    enabled;
	logic                    clr;
	logic                    timeout;
	logic [`WDT_IRQ_W-1:0]   irq_sts_r;
	logic [`WDT_IRQ_W-1:0]   irq_msk_r;
	logic [`WDT_IRQ_W-1:0]   irq_set;
	logic [31:0]             rd_nxt;
	logic                    wr_ctrl;

	// Time-out limit in base ticks for a period-select value
	function automatic logic [CW-1:0] period_limit(input logic [4:0] ps);
		logic [4:0] p;
		p = (ps > `WDT_PS_MAX) ? `WDT_PS_MAX : ps;
		period_limit = CW'((19'h00001 << p) - 19'h00001);
	endfunction

	// Active state from mode, software enable and sleep
	function automatic logic mode_active(input logic [1:0] m,
		input logic swen, input logic slp);
		case (wdt_pkg::wdt_mode_t'(m))
			wdt_pkg::MODE_ON:      mode_active = 1'b1;
			wdt_pkg::MODE_NOSLEEP: mode_active = !slp;
			wdt_pkg::MODE_SW:      mode_active = swen;
			wdt_pkg::MODE_OFF:     mode_active = 1'b0;
			default:               mode_active = 1'b0;
		endcase
	endfunction

	// Oscillator pin crossing; only stages 1 and 2 feed the edge detect
	always_ff @(posedge core_clk) begin
		if (reset) begin
			lf_sync_r <= 3'h0;
		end else begin
			lf_sync_r <= {lf_sync_r[1:0], low_freq_internal_osc};
		end
	end
	assign lf_rise = lf_sync_r[1] && !lf_sync_r[2];

	// 31 oscillator edges make one base tick
	assign tick = lf_rise && (presc_r == `WDT_PRESC_MAX);

	always_ff @(posedge core_clk) begin
		if (reset || clr) begin
			presc_r <= 5'h00;
		end else if (lf_rise) begin
			presc_r <= tick ? 5'h00 : presc_r + 5'h01;
		end
	end

	// Sleep edges
	always_ff @(posedge core_clk) begin
		if (reset) begin
			asleep_r <= 1'b0;
		end else begin
			asleep_r <= core_asleep;
		end
	end
	assign sleep_enter = core_asleep && !asleep_r;
	assign sleep_exit  = !core_asleep && asleep_r;

	assign enabled = mode_active(watchdog_mode_config,
		software_watchdog_enable, core_asleep);

	assign clr = clear_watchdog_instruction || sleep_enter || sleep_exit ||
		osc_fail || oscillator_startup_timer || !enabled;

	assign timeout = enabled && !clr && tick &&
		(count_r == period_limit(timeout_period_select));

	// Counter
	always_ff @(posedge core_clk) begin
		if (reset || clr || timeout) begin
			count_r <= '0;
		end else if (tick) begin
			count_r <= count_r + CW'(1);
		end
	end

	// Control register
	assign wr_ctrl = reg_wr && (reg_addr == `WDT_ADDR_CTRL);

	always_ff @(posedge core_clk) begin
		if (reset) begin
			software_watchdog_enable <= 1'b0;
			timeout_period_select    <= `WDT_PS_DEFAULT;
		end else if (wr_ctrl) begin
			software_watchdog_enable <= reg_wdata[`WDT_CTRL_SWEN];
			timeout_period_select    <=
				reg_wdata[`WDT_CTRL_PS_HI:`WDT_CTRL_PS_LO];
		end
	end

	// Reset or wake request for one cycle
	always_ff @(posedge core_clk) begin
		if (reset) begin
			reset_request <= 1'b0;
			wake_request  <= 1'b0;
		end else begin
			reset_request <= timeout && !core_asleep;
			wake_request  <= timeout && core_asleep;
		end
	end

	// Status flags; the clear instruction clears them, an event wins
	always_ff @(posedge core_clk) begin
		if (reset) begin
			timeout_status_flag <= 1'b0;
			sleep_entry_flag    <= 1'b0;
		end else begin
			if (timeout) begin
				timeout_status_flag <= 1'b1;
			end else if (clear_watchdog_instruction) begin
				timeout_status_flag <= 1'b0;
			end
			if (sleep_enter || (timeout && core_asleep)) begin
				sleep_entry_flag <= 1'b1;
			end else if (clear_watchdog_instruction) begin
				sleep_entry_flag <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			watchdog_active <= 1'b0;
		end else begin
			watchdog_active <= enabled;
		end
	end

	// Interrupt status, write one to clear; a new event wins
	assign irq_set = {timeout && core_asleep, timeout && !core_asleep};

	always_ff @(posedge core_clk) begin
		if (reset) begin
			irq_sts_r <= '0;
		end else if (reg_wr && reg_addr == `WDT_ADDR_IRQ_STS) begin
			irq_sts_r <= (irq_sts_r & ~reg_wdata[`WDT_IRQ_W-1:0]) | irq_set;
		end else begin
			irq_sts_r <= irq_sts_r | irq_set;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			irq_msk_r <= '0;
		end else if (reg_wr && reg_addr == `WDT_ADDR_IRQ_MSK) begin
			irq_msk_r <= reg_wdata[`WDT_IRQ_W-1:0];
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_sts_r & irq_msk_r);
		end
	end

	// Read mux; unmapped addresses read zero
	always_comb begin
		rd_nxt = 32'h0000_0000;
		case (reg_addr)
			`WDT_ADDR_CTRL: begin
				rd_nxt[`WDT_CTRL_SWEN] = software_watchdog_enable;
				rd_nxt[`WDT_CTRL_PS_HI:`WDT_CTRL_PS_LO] =
					timeout_period_select;
			end
			`WDT_ADDR_STATUS: begin
				rd_nxt[3:0] = {watchdog_active, watchdog_mode_config[0],
					sleep_entry_flag, timeout_status_flag};
				rd_nxt[5:4] = watchdog_mode_config;
			end
			`WDT_ADDR_IRQ_STS: rd_nxt[`WDT_IRQ_W-1:0] = irq_sts_r;
			`WDT_ADDR_IRQ_MSK: rd_nxt[`WDT_IRQ_W-1:0] = irq_msk_r;
			`WDT_ADDR_COUNT:   rd_nxt[CW-1:0] = count_r;
			default:           rd_nxt = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			reg_rdata <= rd_nxt;
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

	// Checks
	sequence seq_sleep_enter;
		!core_asleep ##1 core_asleep;
	endsequence

	sequence seq_sleep_exit;
		core_asleep ##1 !core_asleep;
	endsequence

	sequence seq_ost_hold;
		oscillator_startup_timer [*2];
	endsequence

	AST_TICK_PRESCALE: assert property (@(posedge core_clk)
		disable iff (reset)
		(lf_rise && !clr) |=> presc_r ==
			(($past(presc_r) == `WDT_PRESC_MAX) ? 5'h00 :
			$past(presc_r) + 5'h01))
		else $error("Base tick not after 31 oscillator edges");

	AST_MODE_ON: assert property (@(posedge core_clk)
		disable iff (reset)
		(watchdog_mode_config == 2'b11) |=> watchdog_active ||
			$past(watchdog_mode_config) != 2'b11)
		else $error("Mode 11 watchdog not active");

	AST_MODE_NOSLEEP: assert property (@(posedge core_clk)
		disable iff (reset)
		(watchdog_mode_config == 2'b10) ##1
			(watchdog_mode_config == 2'b10) |->
			watchdog_active == !$past(core_asleep))
		else $error("Mode 10 activity does not follow sleep");

	AST_MODE_SW: assert property (@(posedge core_clk)
		disable iff (reset)
		(watchdog_mode_config == 2'b01 && !wr_ctrl) |=>
			watchdog_active == $past(software_watchdog_enable))
		else $error("Mode 01 activity does not follow enable bit");

	AST_MODE_OFF: assert property (@(posedge core_clk)
		disable iff (reset)
		(watchdog_mode_config == 2'b00) |=> !watchdog_active)
		else $error("Mode 00 watchdog active");

	AST_DEFAULT_PERIOD: assert property (@(posedge core_clk)
		disable iff (reset)
		$past(reset) |-> timeout_period_select == `WDT_PS_DEFAULT)
		else $error("Period select not at default after reset");

	AST_TIMEOUT_LIMIT: assert property (@(posedge core_clk)
		disable iff (reset)
		$rose(reset_request || wake_request) |->
			$past(count_r) == period_limit($past(timeout_period_select)))
		else $error("Time-out not at selected period");

	AST_CLEAR: assert property (@(posedge core_clk)
		disable iff (reset)
		(clear_watchdog_instruction || osc_fail) |=> count_r == '0)
		else $error("Counter not cleared");

	AST_SLEEP_ENTER: assert property (@(posedge core_clk)
		disable iff (reset)
		seq_sleep_enter |=> count_r == '0 && sleep_entry_flag)
		else $error("Sleep entry did not clear counter");

	AST_OST_HOLD: assert property (@(posedge core_clk)
		disable iff (reset)
		seq_sleep_exit or seq_ost_hold |=> count_r == '0)
		else $error("Counter not held clear at wake");

	AST_SLEEP_WAKE: assert property (@(posedge core_clk)
		disable iff (reset)
		timeout && core_asleep |=> wake_request && !reset_request
			##1 !wake_request)
		else $error("Sleep time-out did not wake only");

	AST_FLAGS: assert property (@(posedge core_clk)
		disable iff (reset)
		timeout |=> timeout_status_flag &&
			(sleep_entry_flag || !$past(core_asleep)))
		else $error("Time-out flags not updated");

	AST_AWAKE_RESET: assert property (@(posedge core_clk)
		disable iff (reset)
		timeout && !core_asleep |=> reset_request && !wake_request &&
			irq_sts_r[`WDT_IRQ_RST])
		else $error("Awake time-out did not request reset");

	AST_PRESC_BOUND: assert property (@(posedge core_clk)
		disable iff (reset)
		(presc_r <= `WDT_PRESC_MAX))
		else $error("Prescaler beyond its last step");

	// A disabled watchdog neither counts nor requests anything
	AST_DISABLED_CLEAR: assert property (@(posedge core_clk)
		disable iff (reset)
		!enabled |=> count_r == '0 && !reset_request && !wake_request)
		else $error("Disabled watchdog not held clear");

	// Without a competing time-out the clear instruction drops the flag
	AST_FLAG_CLEAR: assert property (@(posedge core_clk)
		disable iff (reset)
		(clear_watchdog_instruction && !timeout) |=> !timeout_status_flag)
		else $error("Clear instruction left time-out flag set");

endmodule

// ---- verification/core_model.sv ----
// Processor core model: periodic clear pulses and sleep entry and exit.
// Assumes the watchdog core runs on the same core_clk.
module core_model (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic reset,
	// Commands from the bench
	input  wire logic kick_en,
	input  wire logic sleep_cmd,
	// Watchdog side
	input  wire logic wake_request,
	output logic      clear_watchdog_instruction,
	output logic      core_asleep
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [8:0] gap_r;
	logic       cmd_r;
	// Clears every 512 cycles, shorter than the periods used with it
	always_ff @(posedge core_clk) begin
		if (reset || !kick_en) begin
			gap_r <= 9'h000;
			clear_watchdog_instruction <= 1'b0;
		end else begin
			gap_r <= gap_r + 9'h001;
			clear_watchdog_instruction <= &gap_r;
		end
	end
	// Sleeps on a rising command; a wake request ends the sleep
	always_ff @(posedge core_clk) begin
		cmd_r <= sleep_cmd;
		if (reset || !sleep_cmd || wake_request)
			core_asleep <= 1'b0;
		else if (!cmd_r)
			core_asleep <= 1'b1;
	end
endmodule

// ---- verification/test_watchdog_timer_core.sv ----
// Self-checking bench for the watchdog timer core.
// Assumes the oscillator pin toggles every 4 clocks, so one tick is near
// 248 clocks.
`include "wdt_consts.svh"
module test_watchdog_timer_core;
	timeunit 1ns;
	timeprecision 1ps;
	logic        core_clk, reset, low_freq_internal_osc, osc_fail;
	logic        oscillator_startup_timer, clear_watchdog_instruction;
	logic        core_asleep, reg_wr, reg_rd, kick_en, sleep_cmd;
	logic [1:0]  watchdog_mode_config, osc_div;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, d;
	logic        reset_request, wake_request, timeout_status_flag;
	logic        sleep_entry_flag, watchdog_active, irq;
	logic [4:0]  rows [8] = '{5'b11001, 5'b11011, 5'b10001, 5'b10010,
		5'b01101, 5'b01111, 5'b01000, 5'b00100};
	int          err_total, compares, cyc, rst_seen, n;
	watchdog_timer_core watchdog_timer_core_inst (.core_clk, .reset,
		.low_freq_internal_osc, .watchdog_mode_config,
		.clear_watchdog_instruction, .core_asleep, .osc_fail,
		.oscillator_startup_timer, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .reset_request, .wake_request, .timeout_status_flag,
		.sleep_entry_flag, .watchdog_active, .irq);
	core_model core_model_inst (.core_clk, .reset, .kick_en, .sleep_cmd,
		.wake_request, .clear_watchdog_instruction, .core_asleep);
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		osc_div <= osc_div + 2'h1;
		if (osc_div == 2'h3)
			low_freq_internal_osc <= ~low_freq_internal_osc;
		cyc <= cyc + 1;
		if (reset_request)
			rst_seen <= rst_seen + 1;
		if (cyc == 20000) begin
			err_total++;
			close_out();
		end
	end
	task automatic close_out();
		$display("Checks %0d, mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, g);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		// Read data stand in this cycle; take them at its closing edge
		@(posedge core_clk);
		d = reg_rdata;
		chk($sformatf("reg %h", a), e, d);
	endtask
	task automatic cyc_wait(input int c);
		repeat (c) @(posedge core_clk);
	endtask
	initial begin
		{reset, osc_fail, oscillator_startup_timer, reg_wr, reg_rd} = '0;
		{low_freq_internal_osc, kick_en, sleep_cmd, osc_div} = '0;
		{reg_addr, reg_wdata, cyc, rst_seen, err_total, compares} = '0;
		watchdog_mode_config = wdt_pkg::MODE_OFF;
		reset = 1'b1;
		cyc_wait(3);
		reset <= 1'b0;
		rd(`WDT_ADDR_CTRL, 32'h0000_0016);
		rd(`WDT_ADDR_STATUS, 32'h0);
		rd(`WDT_ADDR_IRQ_MSK, 32'h0);
		rd(8'h14, 32'h0);
		chk("timeout flag", 1'b0, timeout_status_flag);
		$display("Reset test done");
		foreach (rows[i]) begin
			watchdog_mode_config <= rows[i][4:3];
			wr(`WDT_ADDR_CTRL, {26'h0, 5'h02, rows[i][2]});
			sleep_cmd <= rows[i][1];
			cyc_wait(8);
			chk("active", rows[i][0], watchdog_active);
		end
		sleep_cmd <= 1'b0;
		$display("Mode table done");
		for (int ps = 0; ps < 3; ps++) begin
			watchdog_mode_config <= wdt_pkg::MODE_OFF;
			wr(`WDT_ADDR_CTRL, ps << 1);
			watchdog_mode_config <= wdt_pkg::MODE_ON;
			n = rst_seen;
			cyc_wait((248 << ps) - 24);
			chk("early request", n, rst_seen);
			cyc_wait(48);
			chk("timeout request", n + 1, rst_seen);
		end
		chk("timeout flag", 1'b1, timeout_status_flag);
		chk("masked irq", 1'b0, irq);
		rd(`WDT_ADDR_IRQ_STS, 32'h1);
		wr(`WDT_ADDR_IRQ_MSK, 32'h3);
		cyc_wait(2);
		chk("irq", 1'b1, irq);
		wr(`WDT_ADDR_IRQ_STS, 32'h3);
		cyc_wait(2);
		chk("irq cleared", 1'b0, irq);
		$display("Period test done");
		watchdog_mode_config <= wdt_pkg::MODE_OFF;
		kick_en <= 1'b1;
		wr(`WDT_ADDR_CTRL, 32'h4);
		watchdog_mode_config <= wdt_pkg::MODE_ON;
		n = rst_seen;
		cyc_wait(3000);
		chk("kicked requests", n, rst_seen);
		chk("flag cleared", 1'b0, timeout_status_flag);
		chk("sleep flag cleared", 1'b0, sleep_entry_flag);
		kick_en <= 1'b0;
		// Disable around the write so counting restarts from zero
		watchdog_mode_config <= wdt_pkg::MODE_OFF;
		wr(`WDT_ADDR_CTRL, 32'h8);
		watchdog_mode_config <= wdt_pkg::MODE_ON;
		cyc_wait(600);
		rd(`WDT_ADDR_COUNT, 32'h2);
		osc_fail <= 1'b1;
		rd(`WDT_ADDR_COUNT, 32'h0);
		osc_fail <= 1'b0;
		oscillator_startup_timer <= 1'b1;
		cyc_wait(600);
		rd(`WDT_ADDR_COUNT, 32'h0);
		oscillator_startup_timer <= 1'b0;
		cyc_wait(600);
		sleep_cmd <= 1'b1;
		// Sleep edge reaches the counter two cycles after the command
		cyc_wait(2);
		rd(`WDT_ADDR_COUNT, 32'h0);
		cyc_wait(600);
		rd(`WDT_ADDR_COUNT, 32'h2);
		sleep_cmd <= 1'b0;
		cyc_wait(2);
		rd(`WDT_ADDR_COUNT, 32'h0);
		$display("Clear test done");
		watchdog_mode_config <= wdt_pkg::MODE_OFF;
		wr(`WDT_ADDR_CTRL, 32'h0);
		sleep_cmd <= 1'b1;
		watchdog_mode_config <= wdt_pkg::MODE_ON;
		n = rst_seen;
		for (int i = 0; i < 400 && wake_request !== 1'b1; i++)
			@(posedge core_clk);
		chk("wake", 1'b1, wake_request);
		cyc_wait(2);
		chk("no reset in sleep", n, rst_seen);
		chk("awake", 1'b0, core_asleep);
		chk("timeout flag", 1'b1, timeout_status_flag);
		chk("sleep flag", 1'b1, sleep_entry_flag);
		rd(`WDT_ADDR_STATUS, 32'h3f);
		sleep_cmd <= 1'b0;
		$display("Sleep test done");
		reset <= 1'b1;
		cyc_wait(3);
		reset <= 1'b0;
		rd(`WDT_ADDR_CTRL, 32'h0000_0016);
		chk("flag after reset", 1'b0, timeout_status_flag);
		$display("Second reset test done");
		close_out();
	end
endmodule
